// [rtl/isf_status_top.sv]
// Our own choices: register access over APB and the address map.
`timescale 1ns/1ps
// Overview of operation
// - with range matching on, a nonzero calling address equal to the range address sets the range match flag.
// - with range matching on, a calling address inside the primary to range span also sets the range match flag.
// - any write to control register one clears the range match flag.
// - while addressed as slave, the direction flag shows the read/write bit of the calling address.
// - the direction flag reads 0 for slave receive and 1 for slave transmit.
// - the interrupt flag stays set until software writes a one to it.
// - with fast ack off, the interrupt flag sets when a byte and its acknowledge bit are done.
// - in receive with fast ack on, software picks ack or nack after the interrupt and the block drives that answer.
// - with fast ack on, the interrupt flag sets after the eight data bits, before the acknowledge.
// - any slave address match and lost arbitration set the interrupt flag.
// - in smbus mode every timeout but the scl-high and sda-high ones sets the interrupt flag.
// - with start/stop interrupts on, a detected start or stop sets the interrupt flag.
// - software clears the start/stop seen flag before the interrupt flag, or the interrupt returns.
// - the ack received flag reads 0 after an acknowledged byte and 1 when none was seen.
// - lost arbitration sets a flag that software clears by writing a one.
module isf_status_top (
    input wire logic clock,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [isf_pkg::APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic master_active,
    input wire logic arb_lost_evt,
    input wire logic alert_match,
    input wire logic second_match,
    input wire logic gcall_match,
    input wire logic tmo_scl_low,
    input wire logic tmo_scl_high,
    input wire logic tmo_sda_high,
    output logic irq
);
    import isf_pkg::*;

    typedef struct packed {
        logic [7:0] ctrl1;
        logic [7:0] ctrl2;
        logic [7:0] mask;
        logic [6:0] primary;
        logic [6:0] range_a;
        logic stop_seen;
        logic start_seen;
        logic arb;
        logic range_m;
        logic dir;
        logic irqf;
        logic ackn;
        logic addressed;
        logic sda_oe;
        logic [31:0] rdata;
    } isf_core_t;

    isf_core_t core_r;
    isf_core_t core_nxt;
    isf_link_if lk ();

    logic wr;
    logic [6:0] a7;
    logic addr_done;
    logic prim_hit;
    logic rng_hit;
    logic any_hit;
    logic involved;
    logic byte_set;
    logic irq_set;
    logic irq_clr;
    logic [7:0] status_v;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic reg_mapped(input logic [7:0] a);
        reg_mapped = (a == OFF_STATUS) || (a == OFF_CTRL1) || (a == OFF_CTRL2) || (a == OFF_PRIMARY)
            || (a == OFF_RANGE) || (a == OFF_FILTER) || (a == OFF_MASK);
    endfunction

    // span check works whichever bound is the larger one
    function automatic logic in_span(input logic [6:0] a, input logic [6:0] lo, input logic [6:0] hi);
        if (lo <= hi) begin
            in_span = (a >= lo) && (a <= hi);
        end else begin
            in_span = (a >= hi) && (a <= lo);
        end
    endfunction

    isf_link_mon u_mon (
        .clock(clock),
        .resetn(resetn),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .lk(lk.mon)
    );

    // ------------------------------------------------------------
    // event decode
    // ------------------------------------------------------------
    assign wr = psel & penable & pwrite;
    assign a7 = lk.rx_byte[7:1];
    assign addr_done = lk.bit8_p & lk.addr_phase;
    assign prim_hit = addr_done & (a7 == core_r.primary);
    assign rng_hit = addr_done & core_r.ctrl2[C2_RANGE_MATCH_ENABLE]
        & (((a7 != 7'h00) & (a7 == core_r.range_a))
        | in_span(a7, core_r.primary, core_r.range_a));
    assign any_hit = prim_hit | rng_hit | alert_match | second_match | gcall_match;
    assign involved = core_r.addressed | master_active;
    // fast ack picks whether the flag rises before or after the ack bit
    assign byte_set = involved & (core_r.ctrl2[C2_FAST_ACK_ENABLE] ? lk.bit8_p : lk.byte_p);
    // high timeouts are deliberately left out of the set terms
    assign irq_set = any_hit | arb_lost_evt
        | (core_r.ctrl2[C2_SMB] & tmo_scl_low)
        | (core_r.ctrl2[C2_START_STOP_IRQ_ENABLE] & (core_r.start_seen | core_r.stop_seen))
        | byte_set;
    assign irq_clr = wr & (paddr == OFF_STATUS) & pwdata[ST_IRQ];

    // ------------------------------------------------------------
    // register and flag update
    // ------------------------------------------------------------
    // software effects first, hardware sets afterwards so a set always wins
    always_comb begin
        core_nxt = core_r;
        if (wr) begin
            case (paddr)
                OFF_STATUS: begin
                    // only the two write-one-clear bits react; the rest are read-only
                    if (pwdata[ST_IRQ]) core_nxt.irqf = 1'b0;
                    if (pwdata[ST_ARB]) core_nxt.arb = 1'b0;
                end
                OFF_CTRL1: begin
                    core_nxt.ctrl1 = pwdata[7:0];
                    core_nxt.range_m = 1'b0;
                end
                OFF_CTRL2: core_nxt.ctrl2 = pwdata[7:0];
                OFF_PRIMARY: core_nxt.primary = pwdata[6:0];
                OFF_RANGE: core_nxt.range_a = pwdata[6:0];
                OFF_FILTER: begin
                    if (pwdata[FLT_STOP]) core_nxt.stop_seen = 1'b0;
                    if (pwdata[FLT_START]) core_nxt.start_seen = 1'b0;
                end
                OFF_MASK: core_nxt.mask = pwdata[7:0];
                default: core_nxt.mask = core_r.mask;
            endcase
        end
        if (lk.start_p) core_nxt.start_seen = 1'b1;
        if (lk.stop_p) core_nxt.stop_seen = 1'b1;
        // a new start or a stop ends the slave selection
        if (lk.start_p | lk.stop_p) begin
            core_nxt.addressed = 1'b0;
            core_nxt.dir = 1'b0;
        end
        if (any_hit) begin
            core_nxt.addressed = 1'b1;
            core_nxt.dir = lk.rx_byte[0];
        end
        if (rng_hit) core_nxt.range_m = 1'b1;
        if (arb_lost_evt) core_nxt.arb = 1'b1;
        if (irq_set) core_nxt.irqf = 1'b1;
        if (lk.byte_p & involved) core_nxt.ackn = lk.ack_bit;
        // pull sda low in the ack slot of a received byte unless nack is chosen
        core_nxt.sda_oe = lk.ack_slot & core_r.addressed & ~core_r.dir & ~core_r.ctrl1[C1_ACKSEL];
        // read data is latched in the setup cycle so prdata comes from flops
        if (psel & ~penable & ~pwrite) begin
            case (paddr)
                OFF_STATUS: core_nxt.rdata = {24'h000000, status_v};
                OFF_CTRL1: core_nxt.rdata = {24'h000000, core_r.ctrl1};
                OFF_CTRL2: core_nxt.rdata = {24'h000000, core_r.ctrl2};
                OFF_PRIMARY: core_nxt.rdata = {25'h0000000, core_r.primary};
                OFF_RANGE: core_nxt.rdata = {25'h0000000, core_r.range_a};
                OFF_FILTER: core_nxt.rdata = {30'h00000000, core_r.start_seen, core_r.stop_seen};
                OFF_MASK: core_nxt.rdata = {24'h000000, core_r.mask};
                default: core_nxt.rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            core_r <= '0;
            core_r.ctrl1 <= RST_CTRL;
            core_r.ctrl2 <= RST_CTRL;
            core_r.mask <= RST_MASK;
            core_r.primary <= RST_ADDR;
            core_r.range_a <= RST_ADDR;
        end else begin
            core_r <= core_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // upper status bits belong to other logic and read as zero here
    always_comb begin
        status_v = 8'h00;
        status_v[ST_ARB] = core_r.arb;
        status_v[ST_RANGE] = core_r.range_m;
        status_v[ST_DIR] = core_r.dir & core_r.addressed;
        status_v[ST_IRQ] = core_r.irqf;
        status_v[ST_ACKN] = core_r.ackn;
    end

    assign prdata = core_r.rdata;
    assign pready = penable;
    assign pslverr = psel & penable & ~reg_mapped(paddr);
    assign sda_o = 1'b0;
    assign sda_oe = core_r.sda_oe;
    // only the arbitration and interrupt flags can raise the line
    assign irq = |(status_v & core_r.mask & {3'h0, 1'b1, 2'h0, 1'b1, 1'b0});

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    range_set_a: assert property (@(posedge clock) disable iff (!resetn)
        rng_hit |=> core_r.range_m) else $error("range hit did not set flag");
    range_span_a: assert property (@(posedge clock) disable iff (!resetn)
        addr_done && core_r.ctrl2[C2_RANGE_MATCH_ENABLE] && in_span(a7, core_r.primary, core_r.range_a) |=> core_r.range_m)
        else $error("in-span address missed");
    range_clear_a: assert property (@(posedge clock) disable iff (!resetn)
        wr && paddr == OFF_CTRL1 && !rng_hit |=> !core_r.range_m) else $error("ctrl1 write kept range flag");
    dir_capture_a: assert property (@(posedge clock) disable iff (!resetn)
        any_hit && !lk.start_p |=> core_r.dir == $past(lk.rx_byte[0]) && core_r.addressed)
        else $error("direction not captured");
    irq_hold_a: assert property (@(posedge clock) disable iff (!resetn)
        core_r.irqf && !irq_clr |=> core_r.irqf) else $error("irq flag dropped without clear");
    irq_byte_a: assert property (@(posedge clock) disable iff (!resetn)
        involved && !core_r.ctrl2[C2_FAST_ACK_ENABLE] && lk.byte_p |=> core_r.irqf) else $error("byte end did not set irq");
    irq_fast_a: assert property (@(posedge clock) disable iff (!resetn)
        involved && core_r.ctrl2[C2_FAST_ACK_ENABLE] && lk.bit8_p |=> core_r.irqf) else $error("fast ack did not set irq");
    irq_event_a: assert property (@(posedge clock) disable iff (!resetn)
        any_hit || arb_lost_evt |=> core_r.irqf)
        else $error("match or arbitration irq lost");
    // every other set source is excluded by name, so a high timeout leaking into the set terms trips it
    irq_tmo_a: assert property (@(posedge clock) disable iff (!resetn)
        !core_r.irqf && (tmo_scl_high || tmo_sda_high) && !(any_hit || arb_lost_evt || tmo_scl_low || byte_set
        || (core_r.ctrl2[C2_START_STOP_IRQ_ENABLE] && (core_r.start_seen || core_r.stop_seen))) |=> !core_r.irqf)
        else $error("high timeout raised irq");
    irq_ss_a: assert property (@(posedge clock) disable iff (!resetn)
        core_r.ctrl2[C2_START_STOP_IRQ_ENABLE] && core_r.stop_seen && irq_clr |=> core_r.irqf) else $error("start/stop irq not reasserted");
    ack_drive_a: assert property (@(posedge clock) disable iff (!resetn)
        sda_oe |-> $past(lk.ack_slot) && !$past(core_r.ctrl1[C1_ACKSEL]) && !$past(core_r.dir))
        else $error("ack driven outside slot or on nack");
    ack_capture_a: assert property (@(posedge clock) disable iff (!resetn)
        lk.byte_p && involved |=> core_r.ackn == $past(lk.ack_bit)) else $error("ack received not captured");
    arb_sticky_a: assert property (@(posedge clock) disable iff (!resetn)
        arb_lost_evt |=> core_r.arb ##1 (core_r.arb || $past(wr && paddr == OFF_STATUS && pwdata[ST_ARB])))
        else $error("arbitration flag not sticky");
    ro_write_a: assert property (@(posedge clock) disable iff (!resetn)
        wr && paddr == OFF_STATUS && !pwdata[ST_IRQ] && core_r.irqf |=> core_r.irqf) else $error("zero write cleared irq");
    set_wins_a: assert property (@(posedge clock) disable iff (!resetn)
        irq_set && irq_clr |=> core_r.irqf) else $error("clear beat hardware set");
endmodule

// [rtl/isf_pkg.sv]
package isf_pkg;
    // ------------------------------------------------------------
    // register map, byte addresses on the apb
    // ------------------------------------------------------------
    localparam int APB_AW = 8;
    localparam logic [7:0] OFF_STATUS = 8'h00;
    localparam logic [7:0] OFF_CTRL1 = 8'h04;
    localparam logic [7:0] OFF_CTRL2 = 8'h08;
    localparam logic [7:0] OFF_PRIMARY = 8'h0C;
    localparam logic [7:0] OFF_RANGE = 8'h10;
    localparam logic [7:0] OFF_FILTER = 8'h14;
    localparam logic [7:0] OFF_MASK = 8'h18;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int ST_ARB = 4;
    localparam int ST_RANGE = 3;
    localparam int ST_DIR = 2;
    localparam int ST_IRQ = 1;
    localparam int ST_ACKN = 0;
    localparam int C1_ACKSEL = 3;
    localparam int C2_RANGE_MATCH_ENABLE = 0;
    localparam int C2_FAST_ACK_ENABLE = 1;
    localparam int C2_START_STOP_IRQ_ENABLE = 2;
    localparam int C2_SMB = 3;
    localparam int FLT_STOP = 0;
    localparam int FLT_START = 1;

    // ------------------------------------------------------------
    // reset values and link counts
    // ------------------------------------------------------------
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [7:0] RST_MASK = 8'h00;
    localparam logic [6:0] RST_ADDR = 7'h00;
    localparam logic [3:0] BITS_DATA = 4'h8;
    localparam logic [3:0] BITS_FRAME = 4'h9;

    typedef enum logic [1:0] {
        LK_IDLE = 2'b00,
        LK_ADDR = 2'b01,
        LK_DATA = 2'b11
    } isf_link_state_t;
endpackage

// [rtl/isf_link_if.sv]
`timescale 1ns/1ps
interface isf_link_if;
    logic start_p;
    logic stop_p;
    logic bit8_p;
    logic byte_p;
    logic ack_slot;
    logic ack_bit;
    logic addr_phase;
    logic [7:0] rx_byte;
    modport mon (output start_p, stop_p, bit8_p, byte_p, ack_slot, ack_bit, addr_phase, rx_byte);
    modport core (input start_p, stop_p, bit8_p, byte_p, ack_slot, ack_bit, addr_phase, rx_byte);
endinterface

// [rtl/isf_link_mon.sv]
`timescale 1ns/1ps
module isf_link_mon (
    input wire logic clock,
    input wire logic resetn,
    input wire logic scl_i,
    input wire logic sda_i,
    isf_link_if.mon lk
);
    import isf_pkg::*;

    typedef struct packed {
        logic scl_m;
        logic scl_q;
        logic scl_d;
        logic sda_m;
        logic sda_q;
        logic sda_d;
        isf_link_state_t st;
        logic [3:0] cnt;
        logic [7:0] shreg;
        logic ack_bit;
        logic ack_slot;
        logic start_p;
        logic stop_p;
        logic bit8_p;
        logic byte_p;
    } isf_mon_t;

    isf_mon_t mon_r;
    isf_mon_t mon_nxt;
    logic rise;
    logic fall;

    // ------------------------------------------------------------
    // line sampling and frame tracking
    // ------------------------------------------------------------
    // scl is only sampled, never used as a clock; edges come from the two synced stages
    always_comb begin
        mon_nxt = mon_r;
        mon_nxt.start_p = 1'b0;
        mon_nxt.stop_p = 1'b0;
        mon_nxt.bit8_p = 1'b0;
        mon_nxt.byte_p = 1'b0;
        mon_nxt.scl_m = scl_i;
        mon_nxt.scl_q = mon_r.scl_m;
        mon_nxt.scl_d = mon_r.scl_q;
        mon_nxt.sda_m = sda_i;
        mon_nxt.sda_q = mon_r.sda_m;
        mon_nxt.sda_d = mon_r.sda_q;
        rise = mon_r.scl_q & ~mon_r.scl_d;
        fall = ~mon_r.scl_q & mon_r.scl_d;
        if (mon_r.scl_q & mon_r.scl_d & mon_r.sda_d & ~mon_r.sda_q) begin
            // start or repeated start restarts the address byte
            mon_nxt.st = LK_ADDR;
            mon_nxt.cnt = 4'h0;
            mon_nxt.ack_slot = 1'b0;
            mon_nxt.start_p = 1'b1;
        end else if (mon_r.scl_q & mon_r.scl_d & ~mon_r.sda_d & mon_r.sda_q) begin
            mon_nxt.st = LK_IDLE;
            mon_nxt.cnt = 4'h0;
            mon_nxt.ack_slot = 1'b0;
            mon_nxt.stop_p = 1'b1;
        end else begin
            case (mon_r.st)
                LK_IDLE: begin
                    mon_nxt.cnt = 4'h0;
                end
                LK_ADDR, LK_DATA: begin
                    if (rise) begin
                        if (mon_r.cnt == BITS_DATA) begin
                            mon_nxt.ack_bit = mon_r.sda_q;
                        end else begin
                            mon_nxt.shreg = {mon_r.shreg[6:0], mon_r.sda_q};
                        end
                        mon_nxt.cnt = mon_r.cnt + 4'h1;
                    end
                    if (fall && mon_r.cnt == BITS_DATA && !mon_r.ack_slot) begin
                        mon_nxt.ack_slot = 1'b1;
                        mon_nxt.bit8_p = 1'b1;
                    end else if (fall && mon_r.cnt == BITS_FRAME) begin
                        mon_nxt.ack_slot = 1'b0;
                        mon_nxt.byte_p = 1'b1;
                        mon_nxt.cnt = 4'h0;
                        mon_nxt.st = LK_DATA;
                    end
                end
                default: begin
                    mon_nxt.st = LK_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            mon_r <= '0;
        end else begin
            mon_r <= mon_nxt;
        end
    end

    assign lk.start_p = mon_r.start_p;
    assign lk.stop_p = mon_r.stop_p;
    assign lk.bit8_p = mon_r.bit8_p;
    assign lk.byte_p = mon_r.byte_p;
    assign lk.ack_slot = mon_r.ack_slot;
    assign lk.ack_bit = mon_r.ack_bit;
    assign lk.addr_phase = (mon_r.st == LK_ADDR);
    assign lk.rx_byte = mon_r.shreg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    byte_after_ack_a: assert property (@(posedge clock) disable iff (!resetn)
        mon_r.byte_p |-> $past(mon_r.cnt) == BITS_FRAME) else $error("byte end without nine bits");
endmodule

// [verification/isf_remote_master.sv]
`timescale 1ns/1ps
// ----------------------------------------
// remote bus master, 80 ns bit period
// ----------------------------------------
module isf_remote_master (
    output logic scl,
    output logic sda_low,
    input wire logic sda
);
    // both lines released at rest; the clock stands still between frames
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // start: data falls while the clock is high
    task automatic start_cond();
        #13 sda_low = 1'b0;
        #27 scl = 1'b1;
        #40 sda_low = 1'b1;
        #40 scl = 1'b0;
    endtask
    // data moves only while the clock is low, so no false start or stop;
    // the long low phase lets the device pull its ack before the clock rises
    task automatic put_bit(input logic b, output logic seen);
        #10 sda_low = !b;
        #50 scl = 1'b1;
        #20 seen = sda; // late in the high phase, device answer has settled
        scl = 1'b0;
    endtask
    // eight data bits, msb first, no ack slot
    task automatic send_bits(input logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            put_bit(d[i], s);
        end
    endtask
    // stop: data rises while the clock is high
    task automatic stop_cond();
        #13 sda_low = 1'b1;
        #27 scl = 1'b1;
        #40 sda_low = 1'b0;
        #40;
    endtask
endmodule

// [verification/isf_status_top_bench.sv]
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin miscompares++; \
    $display("wrong value at %0t: got %0h expected %0h", $time, (g), (e)); end end
module isf_status_top_bench;
    import isf_pkg::*;
    // ----------------------------------------
    // stimulus, wiring and the device
    // ----------------------------------------
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, sda_o, sda_oe, irq, scl, m_low;
    logic [6:0] evt = 7'h00;
    logic mact = 1'b0;
    logic [7:0] ev_exp [7] = '{8'h12, 8'h02, 8'h02, 8'h02, 8'h02, 8'h00, 8'h00};
    logic [7:0] rg_byte [3] = '{8'h4A, 8'h50, 8'h52};
    logic [7:0] rg_exp [3] = '{8'h0A, 8'h0A, 8'h00};
    int miscompares = 0;
    int check_count = 0;
    // open-drain data line with pull-up
    wire sda_line = (sda_oe ? sda_o : 1'b1) & !m_low;
    always #5 clock = ~clock;
    isf_remote_master i_rm (.scl(scl), .sda_low(m_low), .sda(sda_line));
    isf_status_top i_dut (.clock(clock), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe),
        .master_active(mact), .arb_lost_evt(evt[0]), .alert_match(evt[1]), .second_match(evt[2]),
        .gcall_match(evt[3]), .tmo_scl_low(evt[4]), .tmo_scl_high(evt[5]), .tmo_sda_high(evt[6]),
        .irq(irq));
    // ----------------------------------------
    // access tasks
    // ----------------------------------------
    task automatic summarize();
        if (miscompares == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // one apb transfer, request held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
        output logic [31:0] rd, output logic err);
        int n;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            miscompares++;
            summarize();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] rd;
        logic e;
        apb(1'b1, a, d, rd, e);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] x);
        logic [31:0] rd;
        logic e;
        apb(1'b0, a, 8'h00, rd, e);
        `CHK(rd, {24'h0, x})
    endtask
    // let link events pass the synchronizer and reach the flags
    task automatic settle();
        repeat (10) @(posedge clock);
    endtask
    task automatic pulse(input int i);
        @(posedge clock);
        evt[i] <= 1'b1;
        @(posedge clock);
        evt[i] <= 1'b0;
    endtask
    // offset keeps link edges off the system clock edges
    task automatic xbyte(input logic [7:0] b, output logic ackn);
        #3 i_rm.send_bits(b);
        i_rm.put_bit(1'b1, ackn);
        settle();
    endtask
    task automatic frame(input logic [7:0] b, output logic ackn);
        i_rm.start_cond();
        xbyte(b, ackn);
        i_rm.stop_cond();
        settle();
    endtask
    // main sequence
    initial begin
        logic [31:0] rd;
        logic err;
        logic ack;
        repeat (8) @(posedge clock);
        resetn <= 1'b1;
        for (int a = 0; a < 28; a += 4) begin
            rd_chk(8'(a), 8'h00);
        end
        apb(1'b0, 8'h1C, 8'h00, rd, err);
        `CHK(err, 1'b1)
        wr(OFF_MASK, 8'h12);
        wr(OFF_PRIMARY, 8'h20);
        i_rm.start_cond();
        xbyte(8'h40, ack);
        `CHK(ack, 1'b0)
        rd_chk(OFF_STATUS, 8'h02);
        `CHK(irq, 1'b1)
        wr(OFF_STATUS, 8'h1D);
        rd_chk(OFF_STATUS, 8'h02);
        wr(OFF_STATUS, 8'h02);
        #1;
        `CHK(irq, 1'b0)
        #3 i_rm.send_bits(8'hA5);
        settle();
        rd_chk(OFF_STATUS, 8'h00);
        #3 i_rm.put_bit(1'b1, ack);
        settle();
        `CHK(ack, 1'b0)
        rd_chk(OFF_STATUS, 8'h02);
        wr(OFF_STATUS, 8'h02);
        wr(OFF_CTRL1, 8'h08);
        wr(OFF_CTRL2, 8'h02);
        #3 i_rm.send_bits(8'h3C);
        settle();
        rd_chk(OFF_STATUS, 8'h02);
        #3 i_rm.put_bit(1'b1, ack);
        settle();
        `CHK(ack, 1'b1)
        rd_chk(OFF_STATUS, 8'h03);
        i_rm.stop_cond();
        wr(OFF_STATUS, 8'h02);
        wr(OFF_CTRL1, 8'h00);
        wr(OFF_CTRL2, 8'h00);
        i_rm.start_cond();
        xbyte(8'h41, ack);
        rd_chk(OFF_STATUS, 8'h07);
        i_rm.stop_cond();
        settle();
        rd_chk(OFF_STATUS, 8'h03);
        wr(OFF_STATUS, 8'h02);
        wr(OFF_RANGE, 8'h28);
        wr(OFF_CTRL2, 8'h01);
        for (int i = 0; i < 3; i++) begin
            frame(rg_byte[i], ack);
            wr(OFF_STATUS, 8'h08);
            rd_chk(OFF_STATUS, rg_exp[i]);
            wr(OFF_CTRL1, 8'h00);
            rd_chk(OFF_STATUS, rg_exp[i] & 8'h02);
            wr(OFF_STATUS, 8'h02);
        end
        wr(OFF_CTRL2, 8'h08);
        for (int i = 0; i < 7; i++) begin
            pulse(i);
            rd_chk(OFF_STATUS, ev_exp[i]);
            `CHK(irq, |ev_exp[i])
            wr(OFF_STATUS, 8'h12);
        end
        pulse(0);
        wr(OFF_MASK, 8'h00);
        #1;
        `CHK(irq, 1'b0)
        wr(OFF_MASK, 8'h12);
        #1;
        `CHK(irq, 1'b1)
        wr(OFF_STATUS, 8'h12);
        rd_chk(OFF_STATUS, 8'h00);
        wr(OFF_CTRL2, 8'h04);
        i_rm.start_cond();
        i_rm.stop_cond();
        settle();
        rd_chk(OFF_FILTER, 8'h03);
        wr(OFF_STATUS, 8'h02);
        rd_chk(OFF_STATUS, 8'h02);
        wr(OFF_FILTER, 8'h03);
        wr(OFF_STATUS, 8'h02);
        rd_chk(OFF_STATUS, 8'h00);
        // master role: an unaddressed byte still raises the flag and captures the missing ack
        wr(OFF_CTRL2, 8'h00);
        mact <= 1'b1;
        frame(8'h52, ack);
        rd_chk(OFF_STATUS, 8'h03);
        summarize();
    end
endmodule
